// [hw/plot_map.vh]
/*
 * Register map, key values and field positions of the protected
 * register lock and oscillator trim block.
 * Assumes byte addresses decoded on the low 12 address bits.
 */
`ifndef PLOT_MAP_VH
`define PLOT_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PLOT_ADDR_W        12
`define PLOT_OFS_LOCK_KEY  12'h100
`define PLOT_OFS_TRIM_CTL  12'h110
`define PLOT_OFS_BANK0     12'h118
`define PLOT_OFS_BANK1     12'h11c
`define PLOT_OFS_BANK2     12'h120

// ----------------------------------------
// Unlock key values
// ----------------------------------------
`define PLOT_KEY1          32'h00000059
`define PLOT_KEY2          32'h00000016
`define PLOT_KEY3          32'h00000088

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PLOT_LOCK_BIT      0
`define PLOT_RANGE_BIT     15
`define PLOT_ACTIVE_TRIM_VALUE_MSB      9
`define PLOT_ACTIVE_TRIM_VALUE_W        10
`define PLOT_BANK_EN_BIT   31
`define PLOT_BANK_TRIM_MSB 15
`define PLOT_BANK_TRIM_W   16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PLOT_LOCK_RST      1'b0
`define PLOT_BANK2_RST     10'h000
`define PLOT_RANGE_RST     1'b0

`endif

// [hw/plot_lock.v]
/*
 * Key-sequence lock guarding the protected registers.
 * Assumes one write strobe per committed bus write and a separate
 * flag telling whether that write hit the lock key register.
 */
`timescale 1ns/1ps
`default_nettype none
`include "plot_map.vh"

module plot_lock (
	// Clock and reset
	input  wire        clk_in,
	input  wire        srst_in,
	input  wire        ce_in,
	// Write commit
	input  wire        wr_in,
	input  wire        key_hit_in,
	input  wire [31:0] wdata_in,
	// Status
	output wire        unlocked_out
);

	// ----------------------------------------
	// Sequence states
	// ----------------------------------------
	localparam [1:0] ST_WAIT1 = 2'd0;
	localparam [1:0] ST_WAIT2 = 2'd1;
	localparam [1:0] ST_WAIT3 = 2'd2;
	localparam [1:0] ST_OPEN  = 2'd3;

	reg [1:0] state_q;
	reg [1:0] state_d;

	always @* begin
		state_d = state_q;
		if (wr_in) begin
			case (state_q)
				// [R03] Abort on mismatch
				// [R15] Back to first key
				ST_WAIT1: state_d = (key_hit_in && wdata_in == `PLOT_KEY1) ? ST_WAIT2 : ST_WAIT1;
				ST_WAIT2: state_d = (key_hit_in && wdata_in == `PLOT_KEY2) ? ST_WAIT3 : ST_WAIT1;
				// [R02] Third key unlocks
				ST_WAIT3: state_d = (key_hit_in && wdata_in == `PLOT_KEY3) ? ST_OPEN : ST_WAIT1;
				// [R05] Any key write relocks
				ST_OPEN:  state_d = key_hit_in ? ST_WAIT1 : ST_OPEN;
				default:  state_d = ST_WAIT1;
			endcase
		end
	end

	// [R01] Locked after reset
	always @(posedge clk_in) begin
		if (srst_in) begin
			state_q <= ST_WAIT1;
		end else if (ce_in) begin
			state_q <= state_d;
		end
	end

	assign unlocked_out = (state_q == ST_OPEN);

endmodule // plot_lock

`default_nettype wire

// [hw/plot_trim_bank.v]
/*
 * One oscillator trim bank: range enable and sign-extended trim.
 * Assumes reset values are presented during the synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "plot_map.vh"

module plot_trim_bank #(
	parameter ACTIVE_TRIM_VALUE_W = 10,
	parameter TRIM_W = 16
) (
	// Clock and reset
	input  wire              clk_in,
	input  wire              srst_in,
	input  wire              ce_in,
	// Reset load
	input  wire [ACTIVE_TRIM_VALUE_W-1:0] init_active_trim_value_in,
	input  wire              init_low_in,
	// Update
	input  wire              load_in,
	input  wire [ACTIVE_TRIM_VALUE_W-1:0] active_trim_value_in,
	input  wire              low_in,
	// State
	output reg  [TRIM_W-1:0] trim_q_out,
	output reg               low_q_out
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// [R14] Sign-extended trim
	always @(posedge clk_in) begin
		if (srst_in) begin
			trim_q_out <= {{(TRIM_W-ACTIVE_TRIM_VALUE_W){init_active_trim_value_in[ACTIVE_TRIM_VALUE_W-1]}}, init_active_trim_value_in};
			low_q_out  <= init_low_in;
		end else if (ce_in && load_in) begin
			trim_q_out <= {{(TRIM_W-ACTIVE_TRIM_VALUE_W){active_trim_value_in[ACTIVE_TRIM_VALUE_W-1]}}, active_trim_value_in};
			low_q_out  <= low_in;
		end
	end

endmodule // plot_trim_bank

`default_nettype wire

// [hw/plot_top.v]
/*
 * AHB-Lite register block: protected register lock key, oscillator
 * trim control register and the three trim banks it mirrors.
 * Assumes bank select comes from the clock controller as a level and
 * factory trims are valid while reset is held.
 */
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "plot_map.vh"

// Function
// [R01] After reset the protected registers are locked until unlocked.
// [R02] Writing 0x59, 0x16, 0x88 in order to the key register unlocks.
// [R03] A wrong value, wrong order or other address aborts the sequence.
// [R04] Reading the key register gives the lock state in bit 0, 1 open.
// [R05] Any write to the key register while unlocked locks again.
// [R06] While locked, writes to protected registers are dropped.
// [R07] Bits 31 to 1 of the key register are reserved and read zero.
// [R08] Bank select 0, 1 or 2 picks which trim bank the control shows.
// [R09] Reset loads factory trims for banks 0 and 1; bank 2 has none.
// [R10] Writing the trim value writes the selected bank, and vice versa.
// [R11] The trim control register is protected by the lock.
// [R12] Control bit 15 picks the low 2MHz range when one, high when zero.
// [R13] Control bits 9 to 0 hold the trim; bits other than 15 are reserved.
// [R14] Each bank holds a 16-bit sign-extended copy of the 10-bit trim.
// [R15] An aborted sequence waits again for the first key.
module plot_top #(
	parameter NBANK  = 3,
	parameter ACTIVE_TRIM_VALUE_W = 10,
	parameter TRIM_W = 16
) (
	// Clock, reset, enable
	input  wire              clk_in,
	input  wire              srst_in,
	input  wire              ce_in,
	// AHB-Lite slave
	input  wire              hsel_in,
	input  wire [31:0]       haddr_in,
	input  wire [1:0]        htrans_in,
	input  wire              hwrite_in,
	input  wire [2:0]        hsize_in,
	input  wire              hready_in,
	input  wire [31:0]       hwdata_in,
	output reg  [31:0]       hrdata_out,
	output wire              hreadyout_out,
	output wire              hresp_out,
	// Clock controller and factory data
	input  wire [1:0]        osc_bank_select_in,
	input  wire [ACTIVE_TRIM_VALUE_W-1:0] factory_trim0_in,
	input  wire [ACTIVE_TRIM_VALUE_W-1:0] factory_trim1_in,
	// Oscillator control
	output reg  [ACTIVE_TRIM_VALUE_W-1:0] active_trim_value_out,
	output reg               osc_range_low_out,
	output reg               unlocked_out
);

	// ----------------------------------------
	// Bus phase tracking
	// ----------------------------------------
	reg                    wr_ph_q;
	reg                    rd_ph_q;
	reg                    rd_ok_q;
	reg [`PLOT_ADDR_W-1:0] addr_q;
	wire                   take;
	wire                   wr_go;
	wire                   unlocked;

	assign take = ce_in & hsel_in & hready_in & htrans_in[1];
	assign wr_go = ce_in & wr_ph_q;

	// Reads take one wait state so read data comes from a flop
	assign hreadyout_out = ce_in & (~rd_ph_q | rd_ok_q);
	assign hresp_out = 1'b0;

	always @(posedge clk_in) begin
		if (srst_in) begin
			wr_ph_q <= 1'b0;
			rd_ph_q <= 1'b0;
			rd_ok_q <= 1'b0;
			addr_q  <= {`PLOT_ADDR_W{1'b0}};
		end else if (ce_in) begin
			if (hready_in) begin
				wr_ph_q <= take & hwrite_in;
				rd_ph_q <= take & ~hwrite_in;
				rd_ok_q <= 1'b0;
				if (take) begin
					addr_q <= haddr_in[`PLOT_ADDR_W-1:0];
				end
			end else if (rd_ph_q) begin
				rd_ok_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Address decode of the data phase
	// ----------------------------------------
	wire hit_key;
	wire hit_ctl;
	wire hit_b0;
	wire hit_b1;
	wire hit_b2;

	assign hit_key = ({2'b00, addr_q[`PLOT_ADDR_W-1:2]} == (`PLOT_OFS_LOCK_KEY >> 2));
	assign hit_ctl = ({2'b00, addr_q[`PLOT_ADDR_W-1:2]} == (`PLOT_OFS_TRIM_CTL >> 2));
	assign hit_b0  = ({2'b00, addr_q[`PLOT_ADDR_W-1:2]} == (`PLOT_OFS_BANK0 >> 2));
	assign hit_b1  = ({2'b00, addr_q[`PLOT_ADDR_W-1:2]} == (`PLOT_OFS_BANK1 >> 2));
	assign hit_b2  = ({2'b00, addr_q[`PLOT_ADDR_W-1:2]} == (`PLOT_OFS_BANK2 >> 2));

	// ----------------------------------------
	// Key-sequence lock
	// ----------------------------------------
	plot_lock u_lock (
		.clk_in       (clk_in),
		.srst_in      (srst_in),
		.ce_in        (ce_in),
		.wr_in        (wr_go),
		.key_hit_in   (hit_key),
		.wdata_in     (hwdata_in),
		.unlocked_out (unlocked)
	);

	// ----------------------------------------
	// Trim banks
	// ----------------------------------------
	wire [NBANK-1:0]        bank_hit;
	wire [NBANK-1:0]        bank_load;
	wire [NBANK-1:0]        bank_low;
	wire [NBANK*TRIM_W-1:0] bank_trim;
	wire [NBANK*ACTIVE_TRIM_VALUE_W-1:0] bank_init;
	wire                    ctl_wr;
	wire [ACTIVE_TRIM_VALUE_W-1:0]       wr_active_trim_value;
	wire                    wr_low;

	assign bank_hit = {hit_b2, hit_b1, hit_b0};

	// [R09] Factory trims, bank two unset
	assign bank_init = {`PLOT_BANK2_RST, factory_trim1_in, factory_trim0_in};

	// [R06] Locked writes dropped
	// [R11] Control is protected
	assign ctl_wr = wr_go & hit_ctl & unlocked;

	// Control write uses bits 9:0 and 15, bank write uses 9:0 and 31
	assign wr_active_trim_value = hwdata_in[`PLOT_ACTIVE_TRIM_VALUE_MSB:0];
	assign wr_low  = hit_ctl ? hwdata_in[`PLOT_RANGE_BIT] : hwdata_in[`PLOT_BANK_EN_BIT];

	genvar gi;
	generate
		for (gi = 0; gi < NBANK; gi = gi + 1) begin : g_bank
			// [R10] Two views stay consistent
			assign bank_load[gi] = (wr_go & bank_hit[gi])
				| (ctl_wr & ({30'h00000000, osc_bank_select_in} == gi));

			plot_trim_bank #(
				.ACTIVE_TRIM_VALUE_W (ACTIVE_TRIM_VALUE_W),
				.TRIM_W (TRIM_W)
			) u_bank (
				.clk_in       (clk_in),
				.srst_in      (srst_in),
				.ce_in        (ce_in),
				.init_active_trim_value_in (bank_init[gi*ACTIVE_TRIM_VALUE_W +: ACTIVE_TRIM_VALUE_W]),
				.init_low_in  (`PLOT_RANGE_RST),
				.load_in      (bank_load[gi]),
				.active_trim_value_in      (wr_active_trim_value),
				.low_in       (wr_low),
				.trim_q_out   (bank_trim[gi*TRIM_W +: TRIM_W]),
				.low_q_out    (bank_low[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Selected bank view
	// ----------------------------------------
	reg [ACTIVE_TRIM_VALUE_W-1:0] sel_active_trim_value;
	reg              sel_low;

	// [R08] Bank select mirror
	always @* begin
		sel_active_trim_value = {ACTIVE_TRIM_VALUE_W{1'b0}};
		sel_low  = 1'b0;
		case (osc_bank_select_in)
			2'd0: begin
				sel_active_trim_value = bank_trim[0*TRIM_W +: ACTIVE_TRIM_VALUE_W];
				sel_low  = bank_low[0];
			end
			2'd1: begin
				sel_active_trim_value = bank_trim[1*TRIM_W +: ACTIVE_TRIM_VALUE_W];
				sel_low  = bank_low[1];
			end
			2'd2: begin
				sel_active_trim_value = bank_trim[2*TRIM_W +: ACTIVE_TRIM_VALUE_W];
				sel_low  = bank_low[2];
			end
			default: begin
				sel_active_trim_value = {ACTIVE_TRIM_VALUE_W{1'b0}};
				sel_low  = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	reg [31:0] rd_d;

	always @* begin
		rd_d = 32'h00000000;
		if (hit_key) begin
			// [R04] Lock state in bit 0
			// [R07] Upper bits read zero
			rd_d[`PLOT_LOCK_BIT] = unlocked;
		end else if (hit_ctl) begin
			// [R12] Range bit
			// [R13] Trim field, rest zero
			rd_d[`PLOT_ACTIVE_TRIM_VALUE_MSB:0]  = sel_active_trim_value;
			rd_d[`PLOT_RANGE_BIT]   = sel_low;
		end else if (hit_b0) begin
			rd_d[`PLOT_BANK_TRIM_MSB:0] = bank_trim[0*TRIM_W +: TRIM_W];
			rd_d[`PLOT_BANK_EN_BIT]     = bank_low[0];
		end else if (hit_b1) begin
			rd_d[`PLOT_BANK_TRIM_MSB:0] = bank_trim[1*TRIM_W +: TRIM_W];
			rd_d[`PLOT_BANK_EN_BIT]     = bank_low[1];
		end else if (hit_b2) begin
			rd_d[`PLOT_BANK_TRIM_MSB:0] = bank_trim[2*TRIM_W +: TRIM_W];
			rd_d[`PLOT_BANK_EN_BIT]     = bank_low[2];
		end
	end

	always @(posedge clk_in) begin
		if (srst_in) begin
			hrdata_out <= 32'h00000000;
		end else if (ce_in && rd_ph_q && !rd_ok_q) begin
			hrdata_out <= rd_d;
		end
	end

	// ----------------------------------------
	// Registered oscillator outputs
	// ----------------------------------------
	always @(posedge clk_in) begin
		if (srst_in) begin
			active_trim_value_out <= {ACTIVE_TRIM_VALUE_W{1'b0}};
			osc_range_low_out     <= `PLOT_RANGE_RST;
			unlocked_out          <= `PLOT_LOCK_RST;
		end else if (ce_in) begin
			active_trim_value_out <= sel_active_trim_value;
			osc_range_low_out     <= sel_low;
			unlocked_out          <= unlocked;
		end
	end

endmodule // plot_top

`default_nettype wire

// [tb/plot_monitor.sv]
/* Checker for plot_top: bus timing, key lock sequence and trim mirroring.
   Assumes one AHB-Lite master, hready_in fed from hreadyout_out, ce_in high. */
`timescale 1ns/1ps
`default_nettype none
`include "plot_map.vh"

module plot_monitor #(
	parameter ACTIVE_TRIM_VALUE_W = 10
) (
	// Clock and reset
	input wire logic              clk_in,
	input wire logic              srst_in,
	// Bus
	input wire logic              hsel_in,
	input wire logic [31:0]       haddr_in,
	input wire logic [1:0]        htrans_in,
	input wire logic              hwrite_in,
	input wire logic              hready_in,
	input wire logic [31:0]       hwdata_in,
	input wire logic [31:0]       hrdata_out,
	input wire logic              hreadyout_out,
	input wire logic              hresp_out,
	// Oscillator
	input wire logic [1:0]        osc_bank_select_in,
	input wire logic [ACTIVE_TRIM_VALUE_W-1:0] active_trim_value_out,
	input wire logic              osc_range_low_out,
	input wire logic              unlocked_out
);
// ----------------------------------------
// Write commit and lock state tracking
// ----------------------------------------
logic        aw_q;
logic [11:0] ad_q;
logic [1:0]  st_q;
logic [1:0]  st_d;
logic        cm;
logic [11:0] sel_ofs;
assign cm = aw_q & hreadyout_out;
assign sel_ofs = `PLOT_OFS_BANK0 + {8'h0, osc_bank_select_in, 2'b00};
always_comb begin
	st_d = (st_q == 2'd3) ? 2'd3 : 2'd0;
	if (ad_q == `PLOT_OFS_LOCK_KEY) begin
		st_d = 2'd0;
		if (st_q == 2'd0 && hwdata_in == `PLOT_KEY1)
			st_d = 2'd1;
		if (st_q == 2'd1 && hwdata_in == `PLOT_KEY2)
			st_d = 2'd2;
		if (st_q == 2'd2 && hwdata_in == `PLOT_KEY3)
			st_d = 2'd3;
	end
end
always_ff @(posedge clk_in) begin
	if (srst_in) begin
		aw_q <= 1'b0;
		ad_q <= 12'h000;
		st_q <= 2'd0;
	end else begin
		aw_q <= hsel_in & hready_in & htrans_in[1] & hwrite_in;
		ad_q <= haddr_in[11:0];
		if (cm)
			st_q <= st_d;
	end
end
// ----------------------------------------
// Sequences and assertions
// ----------------------------------------
default clocking cb @(posedge clk_in); endclocking
default disable iff (srst_in);
sequence rd_take;
	hsel_in && hready_in && htrans_in[1] && !hwrite_in;
endsequence
sequence rd_done;
	!hreadyout_out ##1 hreadyout_out;
endsequence
sequence key_last;
	cm && st_q == 2'd2 && st_d == 2'd3;
endsequence
chk_read_wait:
	assert property (rd_take |=> rd_done) else $error("read wait wrong");
chk_key_read:
	assert property (rd_take and haddr_in[11:0] == `PLOT_OFS_LOCK_KEY |-> ##2
		hrdata_out[31:1] == 31'h0) else $error("key reserved bits set");
chk_reset_locked:
	assert property ($fell(srst_in) |-> !unlocked_out) else $error("open after reset");
chk_lock_track:
	assert property (unlocked_out == ($past(st_q) == 2'd3)) else $error("lock state wrong");
chk_unlock_seq:
	assert property (key_last |-> ##2 unlocked_out) else $error("no unlock");
chk_relock_write:
	assert property (cm && st_q == 2'd3 && st_d == 2'd0 |-> ##2 !unlocked_out)
		else $error("no relock");
chk_trim_hold:
	assert property (cm && ad_q == `PLOT_OFS_TRIM_CTL && st_q != 2'd3 |=> ##1
		$stable(active_trim_value_out) && $stable(osc_range_low_out))
		else $error("locked write took");
chk_trim_write:
	assert property (cm && ad_q == `PLOT_OFS_TRIM_CTL && st_q == 2'd3 &&
		osc_bank_select_in != 2'd3 |=> ##1 active_trim_value_out == $past(hwdata_in[9:0], 2)
		&& osc_range_low_out == $past(hwdata_in[15], 2)) else $error("trim write lost");
chk_bank_mirror:
	assert property (cm && ad_q == sel_ofs && osc_bank_select_in != 2'd3 |=> ##1
		active_trim_value_out == $past(hwdata_in[9:0], 2)) else $error("bank not mirrored");
chk_resp_okay:
	assert property (hresp_out == 1'b0) else $error("response not okay");
endmodule // plot_monitor

bind plot_top plot_monitor #(.ACTIVE_TRIM_VALUE_W(ACTIVE_TRIM_VALUE_W)) u_mon (
	.clk_in(clk_in),
	.srst_in(srst_in),
	.hsel_in(hsel_in),
	.haddr_in(haddr_in),
	.htrans_in(htrans_in),
	.hwrite_in(hwrite_in),
	.hready_in(hready_in),
	.hwdata_in(hwdata_in),
	.hrdata_out(hrdata_out),
	.hreadyout_out(hreadyout_out),
	.hresp_out(hresp_out),
	.osc_bank_select_in(osc_bank_select_in),
	.active_trim_value_out(active_trim_value_out),
	.osc_range_low_out(osc_range_low_out),
	.unlocked_out(unlocked_out)
);
`default_nettype wire

// [tb/tb.sv]
/* Bench for plot_top: key sequences, trim control and bank mirroring.
   Assumes the monitor is bound in from its own file. */
`timescale 1ns/1ps
`default_nettype none
`include "plot_map.vh"

module tb;
// ----------------------------------------
// Signals
// ----------------------------------------
logic        clk_in;
logic        srst_in;
logic        hsel;
logic [31:0] haddr;
logic [1:0]  htrans;
logic        hwrite;
logic [31:0] hwdata;
wire  [31:0] hrdata;
wire         hrdy;
logic [1:0]  sel;
logic [9:0]  f0;
logic [9:0]  f1;
wire  [9:0]  trim;
wire         low;
wire         unl;
logic [31:0] seed;
logic [31:0] v;
logic [31:0] rdv;
logic [31:0] exp_v;
logic [11:0] ba;
logic [31:0] seqd [16];
int          mismatches;
int          comparisons;
int          cycles;

plot_top u_dut (
	.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1),
	.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
	.hsize_in(3'b010), .hready_in(hrdy), .hwdata_in(hwdata), .hrdata_out(hrdata),
	.hreadyout_out(hrdy), .hresp_out(), .osc_bank_select_in(sel),
	.factory_trim0_in(f0), .factory_trim1_in(f1), .active_trim_value_out(trim),
	.osc_range_low_out(low), .unlocked_out(unl)
);

// ----------------------------------------
// Helpers
// ----------------------------------------
function logic [31:0] rnd();
	seed = seed ^ (seed << 13);
	seed = seed ^ (seed >> 17);
	seed = seed ^ (seed << 5);
	return seed;
endfunction
function automatic logic [31:0] bw(input logic l, input logic [9:0] x);
	return {l, 15'h0, {6{x[9]}}, x};
endfunction
function automatic logic [31:0] cw(input logic l, input logic [9:0] x);
	return {16'h0, l, 5'h0, x};
endfunction
task automatic ck(input string n, input logic [31:0] e, input logic [31:0] s);
	comparisons++;
	if (s !== e) begin
		mismatches++;
		$display("MISMATCH %s expected %h seen %h", n, e, s);
	end
endtask
task automatic wt();
	@(posedge clk_in);
	while (hrdy !== 1'b1)
		@(posedge clk_in);
endtask
task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
	hsel <= 1'b1;
	haddr <= {20'h0, a};
	htrans <= 2'b10;
	hwrite <= w;
	wt();
	hsel <= 1'b0;
	htrans <= 2'b00;
	hwdata <= d;
	wt();
	rdv = hrdata;
endtask
task automatic rst();
	v = rnd();
	f0 <= v[9:0];
	f1 <= v[25:16];
	sel <= 2'd0;
	srst_in <= 1'b1;
	repeat (3) @(posedge clk_in);
	srst_in <= 1'b0;
	@(posedge clk_in);
endtask
task automatic results();
	if (mismatches == 0 && comparisons > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask

// ----------------------------------------
// Clock and timeout
// ----------------------------------------
initial begin
	clk_in = 1'b0;
	forever #2 clk_in = ~clk_in;
end
always @(posedge clk_in) begin
	cycles <= cycles + 1;
	if (cycles == 5000) begin
		mismatches++;
		results();
	end
end

// ----------------------------------------
// Scenarios
// ----------------------------------------
initial begin
	seed = 32'h7d7894a4;
	mismatches = 0;
	comparisons = 0;
	cycles = 0;
	srst_in = 1'b1;
	hsel = 1'b0;
	haddr = 32'h0;
	htrans = 2'b00;
	hwrite = 1'b0;
	hwdata = 32'h0;
	sel = 2'd0;
	f0 = 10'h0;
	f1 = 10'h0;
	seqd = '{32'h59, 32'h59, 32'h16, 32'h88, 32'h59, 32'h80000000, 32'h16, 32'h88,
		32'h59, 32'h16, 32'h87, 32'h88, 32'h159, 32'h59, 32'h16, 32'h88};
	for (int r = 0; r < 2; r++) begin
		rst();
		xf(0, `PLOT_OFS_LOCK_KEY, 32'h0);
		ck("lock_key", 32'h0, rdv);
		xf(0, `PLOT_OFS_BANK0, 32'h0);
		ck("bank0", bw(1'b0, f0), rdv);
		xf(0, `PLOT_OFS_BANK1, 32'h0);
		ck("bank1", bw(1'b0, f1), rdv);
		xf(0, `PLOT_OFS_BANK2, 32'h0);
		ck("bank2", 32'h0, rdv);
		xf(0, `PLOT_OFS_TRIM_CTL, 32'h0);
		ck("trim_ctl", cw(1'b0, f0), rdv);
		for (int i = 0; i < 16; i++) begin
			xf(1, seqd[i][31] ? 12'h124 : `PLOT_OFS_LOCK_KEY, seqd[i]);
			if (i % 4 == 3) begin
				xf(0, `PLOT_OFS_LOCK_KEY, 32'h0);
				ck("unlock", {31'h0, i == 15}, rdv);
				ck("unlocked", {31'h0, i == 15}, {31'h0, unl});
			end
		end
		xf(0, 12'h124, 32'h0);
		ck("unmapped", 32'h0, rdv);
		for (int s = 0; s < 3; s++) begin
			sel <= s[1:0];
			ba = `PLOT_OFS_BANK0 + {s[9:0], 2'b00};
			v = rnd();
			xf(1, `PLOT_OFS_TRIM_CTL, v);
			xf(0, ba, 32'h0);
			ck("bank_sel", bw(v[15], v[9:0]), rdv);
			xf(0, `PLOT_OFS_TRIM_CTL, 32'h0);
			ck("trim_ctl", cw(v[15], v[9:0]), rdv);
			v = rnd();
			xf(1, ba, v);
			xf(0, `PLOT_OFS_TRIM_CTL, 32'h0);
			exp_v = cw(v[31], v[9:0]);
			ck("bank_mirror", exp_v, rdv);
			ck("trim_port", {22'h0, v[9:0]}, {22'h0, trim});
			ck("range_port", {31'h0, v[31]}, {31'h0, low});
		end
		xf(1, `PLOT_OFS_LOCK_KEY, rnd());
		xf(0, `PLOT_OFS_LOCK_KEY, 32'h0);
		ck("relock", 32'h0, rdv);
		xf(1, `PLOT_OFS_TRIM_CTL, rnd());
		xf(0, `PLOT_OFS_TRIM_CTL, 32'h0);
		ck("locked_write", exp_v, rdv);
	end
	results();
end
endmodule // tb
`default_nettype wire
